// >>> hw/pcc_clock_control.v
`include "pcc_consts.vh"

// Clock output control: picks the source for the auxiliary clock
// pin, configures the PLL and exposes the registers over a
// classic Wishbone slave with 32-bit data.
module pcc_clock_control #(
    parameter ADDR_W = 10
) (
    input  wire              clk,
    input  wire              reset_n,
    // Wishbone slave
    input  wire              cyc_i,
    input  wire              stb_i,
    input  wire              we_i,
    input  wire [ADDR_W-1:0] adr_i,
    input  wire [3:0]        sel_i,
    input  wire [31:0]       dat_i,
    output reg  [31:0]       dat_o,
    output reg               ack_o,
    // Sampled crystal clock level
    input  wire              xtalLevel,
    // Sampled first-stage PLL clock level
    input  wire              pllStageOneLevel,
    // Timer overflow pulses
    input  wire              timerZeroOverflow,
    input  wire              timerOneOverflow,
    input  wire              timerTwoOverflow,
    input  wire              timerThreeOverflow,
    // Auxiliary clock pin
    input  wire              auxClockPinIn,
    output reg               auxClockPinOut,
    output reg               auxClockPinOe,
    // Analog PLL controls
    output reg               pllPowerDown,
    output reg  [4:0]        pllMultiplier
);

    // Data flow in short: software writes the control byte and the
    // output ratio; the selector then picks one of several levels and
    // a single flip-flop stage drives the pin from that level.
    //
    // Every clock-like input arrives as a sampled level, not as a
    // clock, so the whole block runs on clk alone. The hazard this
    // avoids is a second clock domain inside the selector; the price
    // is that a source can only be shown at up to half the clk rate,
    // and that its edges are quantised to clk edges.
    //
    // The analog PLL itself sits outside. This block only tells it
    // whether to run and which multiplier to use, and divides the
    // first-stage level that comes back.
    //
    // Registers are single bytes on a 32-bit bus; the upper bits of
    // every read are zero except in the status word, which packs the
    // pin state, two sanity flags and the multiplier in use.

    // Codes 00 and 11 share one factor, so the default branch
    // covers both and no code is left undecoded.
    // Feedback code to multiplication factor
    function [4:0] fbFactor;
        input [1:0] code;
        begin
            case (code)
                2'b01:   fbFactor = `PCC_FB_FACTOR_B;  // R9
                2'b10:   fbFactor = `PCC_FB_FACTOR_C;  // R9
                default: fbFactor = `PCC_FB_FACTOR_A;  // R9
            endcase
        end
    endfunction

    // Output divider ratio inside its legal range
    function ratioLegal;
        input [7:0] value;
        begin
            ratioLegal = (value >= `PCC_RATIO_MIN) &&
                         (value <= `PCC_RATIO_MAX);
        end
    endfunction

    // Software registers
    reg  [7:0] ctrl_reg;        // Pin and PLL control
    reg  [7:0] outRatio_reg;    // PLL output divider ratio

    // Control fields
    wire [3:0] sourceSelect;    // clock_out_source_select
    wire       driveEnable;     // clock_out_drive_enable
    wire       powerDown;       // pll_power_down
    wire [1:0] feedbackRatio;   // pll_feedback_ratio

    assign sourceSelect  = ctrl_reg[`PCC_SEL_MSB:`PCC_SEL_LSB];
    assign driveEnable   = ctrl_reg[`PCC_DRIVE_EN_BIT];
    assign powerDown     = ctrl_reg[`PCC_POWER_DOWN_BIT];
    assign feedbackRatio = ctrl_reg[`PCC_FB_MSB:`PCC_FB_LSB];

    // Only the word index is decoded; the two lowest address bits
    // and the upper byte lanes are ignored, as every writable register holds
    // a single byte in bits 7:0.
    // Bus decode
    wire [7:0] regIndex;        // Word index of the access
    wire       busRequest;      // New request this cycle
    wire       busWrite;        // Write with low byte lane on

    assign regIndex   = adr_i[9:2];
    assign busRequest = cyc_i && stb_i && !ack_o;
    assign busWrite   = busRequest && we_i && sel_i[0];

    // Both previous-level flops reset low, the idle level of both
    // inputs, so no false rising edge follows reset.
    // Edge detection on the sampled clock inputs
    reg        xtalPrev_reg;    // Crystal level one cycle ago
    reg        stageOnePrev_reg;// First-stage level one cycle ago
    wire       xtalRise;        // Crystal rising edge
    wire       stageOneRise;    // First-stage rising edge

    assign xtalRise     = xtalLevel && !xtalPrev_reg;
    assign stageOneRise = pllStageOneLevel && !stageOnePrev_reg;

    // Crystal ripple divider: bit n gives divide by 2^(n+1)
    reg  [2:0] xtalDiv_reg;

    // Timer-driven toggle level
    reg        timerToggle_reg;
    reg        timerHit;        // Overflow of the selected timer

    // The PLL runs only with power-down clear and a legal ratio.
    // PLL second stage
    wire       pllRun;          // PLL running with a legal ratio
    wire       pllDivLevel;     // Divided PLL clock

    assign pllRun = !powerDown && ratioLegal(outRatio_reg);  // R8 R11

    // Selected source
    reg        sourceLevel;     // Level chosen by the selector
    reg        sourceValid;     // Selector names a clock duty

    // Writes land at the edge on which the request is taken, so a
    // read right after a write already returns the new byte. Status
    // and unmapped indices swallow writes but still answer, which
    // keeps a stray access from hanging the bus.
    // Register writes; only the low byte lane carries data
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg     <= `PCC_CTRL_RESET;
            outRatio_reg <= `PCC_OUT_RATIO_RESET;
        end else if (busWrite) begin
            case (regIndex)
                `PCC_IDX_CTRL:      ctrl_reg     <= dat_i[7:0];
                `PCC_IDX_OUT_RATIO: outRatio_reg <= dat_i[7:0];
                default: ;          // Unmapped or read-only
            endcase
        end
    end

    // The ack is registered and the request term includes !ack_o, so
    // a master that keeps strobing after the answer is not counted
    // twice. Read data is captured with the ack and then held until
    // the next read, which lets a slow master pick it up late.
    // Bus answer: ack one cycle after the request, read data with it
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= busRequest;
            if (busRequest && !we_i) begin
                case (regIndex)
                    `PCC_IDX_CTRL:
                        dat_o <= {24'h000000, ctrl_reg};
                    `PCC_IDX_OUT_RATIO:
                        dat_o <= {24'h000000, outRatio_reg};
                    `PCC_IDX_STATUS: begin
                        dat_o <= 32'h00000000;
                        dat_o[`PCC_ST_PIN_IN_BIT]  <= auxClockPinIn;
                        dat_o[`PCC_ST_PIN_OUT_BIT] <= auxClockPinOut;
                        dat_o[`PCC_ST_PIN_OE_BIT]  <= auxClockPinOe;
                        dat_o[`PCC_ST_RATIO_BAD]   <=
                            !ratioLegal(outRatio_reg);
                        dat_o[`PCC_ST_SEL_BAD]     <=
                            (sourceSelect > `PCC_SRC_TIMER_THREE);
                        dat_o[`PCC_ST_MULT_LSB+4:`PCC_ST_MULT_LSB] <=
                            pllMultiplier;
                    end
                    default:
                        dat_o <= 32'h00000000;  // Unmapped reads zero
                endcase
            end
        end
    end

    // Previous levels for edge detection
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            xtalPrev_reg     <= 1'b0;
            stageOnePrev_reg <= 1'b0;
        end else begin
            xtalPrev_reg     <= xtalLevel;
            stageOnePrev_reg <= pllStageOneLevel;
        end
    end

    // Ripple count of crystal edges. Each bit halves the rate of the
    // one below; the divide-by-one case bypasses the counter and uses
    // the sampled level straight. The counter runs freely, so a switch
    // between two divided rates keeps the phase of the count.
    // Crystal divisions counted on crystal rising edges
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            xtalDiv_reg <= 3'h0;
        end else if (xtalRise) begin
            xtalDiv_reg <= xtalDiv_reg + 3'h1;  // R4
        end
    end

    // Overflow of the timer that the selector names
    always @* begin
        case (sourceSelect)
            `PCC_SRC_TIMER_ZERO: timerHit = timerZeroOverflow;
            `PCC_SRC_TIMER_ONE: timerHit = timerOneOverflow;
            `PCC_SRC_TIMER_TWO: timerHit = timerTwoOverflow;
            `PCC_SRC_TIMER_THREE: timerHit = timerThreeOverflow;
            default:         timerHit = 1'b0;
        endcase
    end

    // Only the timer that the selector names can flip the level, so
    // overflows of the other timers are ignored. The level is not
    // cleared on a change of selector, nor by selecting low or high:
    // only reset brings it back to a known low starting level.
    // Toggle on each selected overflow; level kept across switches
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timerToggle_reg <= 1'b0;
        end else if (timerHit) begin
            timerToggle_reg <= !timerToggle_reg;  // R5
        end
    end

    // The divider stops and rests low while the PLL is powered down
    // or the ratio lies outside its legal range. Reserved ratios are
    // thus never divided, and the pin shows no rate that software
    // did not ask for. Halving the ratio for the high time means an
    // odd ratio gives a slightly short high phase.
    // Second stage of the PLL divides first-stage edges
    pcc_ratio_divider #(
        .WIDTH    (8)
    ) u_out_divider (
        .clk      (clk),
        .reset_n  (reset_n),
        .run      (pllRun),
        .tickIn   (stageOneRise),
        .ratio    (outRatio_reg),
        .levelOut (pllDivLevel)
    );

    // The selector is purely combinational; its output only reaches
    // the pin through the registered stage below, so decode glitches
    // during a control write never show on the pin.
    // Source selection
    always @* begin
        sourceLevel = 1'b0;
        sourceValid = 1'b1;
        case (sourceSelect)
            `PCC_SRC_PLL:       sourceLevel = pllDivLevel;     // R2
            `PCC_SRC_LOW:       sourceLevel = 1'b0;            // R3
            `PCC_SRC_HIGH:      sourceLevel = 1'b1;            // R3
            `PCC_SRC_XTAL_DIV1: sourceLevel = xtalLevel;       // R4
            `PCC_SRC_XTAL_DIV2: sourceLevel = xtalDiv_reg[0];  // R4
            `PCC_SRC_XTAL_DIV4: sourceLevel = xtalDiv_reg[1];  // R4
            `PCC_SRC_XTAL_DIV8: sourceLevel = xtalDiv_reg[2];  // R4
            `PCC_SRC_TIMER_ZERO,
            `PCC_SRC_TIMER_ONE,
            `PCC_SRC_TIMER_TWO,
            `PCC_SRC_TIMER_THREE:    sourceLevel = timerToggle_reg; // R5
            default: begin
                // General I/O and reserved codes both release the pin
                sourceValid = 1'b0;  // R1 R6
            end
        endcase
    end

    // With the enable clear the pin is released and its output bit
    // rests low, so a later enable starts from a defined level.
    // Pin drive: registered so the pin never glitches from decode
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            auxClockPinOut <= 1'b0;
            auxClockPinOe  <= 1'b0;
        end else begin
            auxClockPinOe  <= sourceValid && driveEnable;  // R1 R7
            auxClockPinOut <= sourceValid && driveEnable &&
                              sourceLevel;                 // R7
        end
    end

    // The PLL controls are registered copies of the control byte.
    // They follow a write one cycle later, which gives the analog
    // side clean levels; the halving of the first stage happens
    // inside the analog block and is not modelled here.
    // Analog PLL controls; the first stage multiplies and halves
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pllPowerDown  <= 1'b0;
            pllMultiplier <= `PCC_FB_FACTOR_A;
        end else begin
            pllPowerDown  <= powerDown;                  // R8
            pllMultiplier <= fbFactor(feedbackRatio);    // R9 R10
        end
    end

endmodule

// >>> hw/pcc_consts.vh
// Overview of operation
// R1: Select 0h releases pin for general I/O
// R2: Select 1h routes PLL output to pin
// R3: Select 2h holds pin low, 3h high
// R4: Selects 4h-7h give crystal divided 1,2,4,8
// R5: Selects 8h-Bh toggle pin on timer overflow
// R6: Software avoids reserved selects Ch to Fh
// R7: Control bit 3 gates clock onto pin
// R8: Power-down bit 2 stops the PLL
// R9: Feedback code 00/11=23, 01=27, 10=28
// R10: First stage multiplies crystal, then halves
// R11: Output divider valid 8 to 254 only
// R12: Second stage divides by output ratio
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH

// Register indices; byte address is four times the index
`define PCC_IDX_CTRL        8'h3D
`define PCC_IDX_OUT_RATIO   8'h3E
`define PCC_IDX_STATUS      8'h30

// Control register fields
`define PCC_SEL_MSB         7
`define PCC_SEL_LSB         4
`define PCC_DRIVE_EN_BIT    3
`define PCC_POWER_DOWN_BIT  2
`define PCC_FB_MSB          1
`define PCC_FB_LSB          0

// Reset values
`define PCC_CTRL_RESET      8'h00
`define PCC_OUT_RATIO_RESET 8'h08

// Source select codes
`define PCC_SRC_GPIO        4'h0
`define PCC_SRC_PLL         4'h1
`define PCC_SRC_LOW         4'h2
`define PCC_SRC_HIGH        4'h3
`define PCC_SRC_XTAL_DIV1   4'h4
`define PCC_SRC_XTAL_DIV2   4'h5
`define PCC_SRC_XTAL_DIV4   4'h6
`define PCC_SRC_XTAL_DIV8   4'h7
`define PCC_SRC_TIMER_ZERO      4'h8
`define PCC_SRC_TIMER_ONE      4'h9
`define PCC_SRC_TIMER_TWO      4'hA
`define PCC_SRC_TIMER_THREE      4'hB

// Feedback multiplication factors
`define PCC_FB_FACTOR_A     5'h17
`define PCC_FB_FACTOR_B     5'h1B
`define PCC_FB_FACTOR_C     5'h1C

// Output divider legal range
`define PCC_RATIO_MIN       8'h08
`define PCC_RATIO_MAX       8'hFE

// Status register fields
`define PCC_ST_PIN_IN_BIT   0
`define PCC_ST_PIN_OUT_BIT  1
`define PCC_ST_PIN_OE_BIT   2
`define PCC_ST_RATIO_BAD    3
`define PCC_ST_SEL_BAD      4
`define PCC_ST_MULT_LSB     8

`endif

// >>> hw/pcc_ratio_divider.v
`include "pcc_consts.vh"

// Divides a stream of tick pulses by a programmable ratio.
// The output is high for the first half of each period.
module pcc_ratio_divider #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             reset_n,
    input  wire             run,
    input  wire             tickIn,
    input  wire [WIDTH-1:0] ratio,
    output reg              levelOut
);

    reg  [WIDTH-1:0] count_reg;   // Ticks counted in this period
    reg  [WIDTH-1:0] count_next;  // Count after this cycle
    wire [WIDTH-1:0] lastCount;   // Final count of a period

    assign lastCount = ratio - {{(WIDTH-1){1'b0}}, 1'b1};

    // Next count: wrap at the ratio, restart when stopped
    always @* begin
        count_next = count_reg;
        if (!run) begin
            count_next = {WIDTH{1'b0}};
        end else if (tickIn) begin
            if (count_reg >= lastCount) begin
                count_next = {WIDTH{1'b0}};  // R12
            end else begin
                count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // Count and output level; stopped divider rests low
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= {WIDTH{1'b0}};
            levelOut  <= 1'b0;
        end else begin
            count_reg <= count_next;
            levelOut  <= run && (count_next < (ratio >> 1));  // R12
        end
    end

endmodule

// >>> bench/pcc_checker.sv
`include "pcc_consts.vh"

// Watches the bus and the pin against a shadow of the control byte
module pcc_checker #(
    parameter ADDR_W = 10
) (
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              cyc_i,
    input wire logic              stb_i,
    input wire logic              we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0]        sel_i,
    input wire logic [31:0]       dat_i,
    input wire logic [31:0]       dat_o,
    input wire logic              ack_o,
    input wire logic              timerZeroOverflow,
    input wire logic              auxClockPinOut,
    input wire logic              auxClockPinOe,
    input wire logic              pllPowerDown,
    input wire logic [4:0]        pllMultiplier
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh_reg;     // Control byte as software last wrote it
    wire        taken = cyc_i && stb_i && !ack_o;
    wire        shWr = taken && we_i && sel_i[0]
                       && adr_i[9:2] == `PCC_IDX_CTRL;
    // Shadow follows taken writes only, so a refused lane is ignored
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            sh_reg <= `PCC_CTRL_RESET;
        else if (shWr)
            sh_reg <= dat_i[7:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_ack; taken |=> ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    property p_pulse; ack_o |=> !ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack too long");
    property p_cause; ack_o |-> $past(taken); endproperty
    a_cause: assert property (p_cause) else $error("stray ack");
    property p_rdctl;
        ack_o && !we_i && adr_i[9:2] == `PCC_IDX_CTRL
            |-> dat_o == {24'h000000, sh_reg};
    endproperty
    a_rdctl: assert property (p_rdctl) else $error("ctrl readback");
    property p_mult;
        $stable(sh_reg) |-> pllMultiplier == (sh_reg[1:0] == 2'b01
            ? 5'h1B : sh_reg[1:0] == 2'b10 ? 5'h1C : 5'h17);
    endproperty
    a_mult: assert property (p_mult) else $error("bad multiplier");
    property p_pd; $stable(sh_reg) |-> pllPowerDown == sh_reg[2]; endproperty
    a_pd: assert property (p_pd) else $error("power down wrong");
    property p_low;
        $stable(sh_reg) && sh_reg[7:3] == 5'h05
            |-> auxClockPinOe && !auxClockPinOut;
    endproperty
    a_low: assert property (p_low) else $error("pin not low");
    property p_high;
        $stable(sh_reg) && sh_reg[7:3] == 5'h07
            |-> auxClockPinOe && auxClockPinOut;
    endproperty
    a_high: assert property (p_high) else $error("pin not high");
    property p_rel;
        $stable(sh_reg) && (sh_reg[7:4] == 4'h0 || !sh_reg[3]
            || sh_reg[7:6] == 2'b11) |-> !auxClockPinOe;
    endproperty
    a_rel: assert property (p_rel) else $error("pin not released");
    property p_tmr;
        $stable(sh_reg) && sh_reg[7:3] == 5'h11 && timerZeroOverflow
            |=> ##1 auxClockPinOut != $past(auxClockPinOut);
    endproperty
    a_tmr: assert property (p_tmr) else $error("no toggle");
    c_wr: cover property (shWr);
    c_rd: cover property (ack_o && !we_i);
    c_tmr: cover property (sh_reg[7:3] == 5'h11 && timerZeroOverflow);
endmodule

bind pcc_clock_control pcc_checker #(.ADDR_W(ADDR_W)) chk (
    .clk(clk), .reset_n(reset_n), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .timerZeroOverflow(timerZeroOverflow),
    .auxClockPinOut(auxClockPinOut), .auxClockPinOe(auxClockPinOe),
    .pllPowerDown(pllPowerDown), .pllMultiplier(pllMultiplier));

// >>> bench/pcc_pin_load.sv
// Board load on the clock pin: pull-up plus an edge counter
module pcc_pin_load (
    input  wire logic clk,
    input  wire logic clear,
    input  wire logic pinOut,
    input  wire logic pinOe,
    output logic      pinLevel,
    output int        riseCount
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lastLevel = 1'b1; // Pull-up level before anything drives
    // Released pin floats up, so a stuck-low driver stays visible
    assign pinLevel = pinOe ? pinOut : 1'b1;
    // Counts rising edges as a clocked load would see them
    always @(posedge clk) begin
        if (clear)
            riseCount <= 0;
        else if (pinLevel && !lastLevel)
            riseCount <= riseCount + 1;
        lastLevel <= pinLevel;
    end
endmodule

// >>> bench/tb.sv
`include "pcc_consts.vh"

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [9:0] A_CTL = {`PCC_IDX_CTRL, 2'b00};
    localparam logic [9:0] A_RAT = {`PCC_IDX_OUT_RATIO, 2'b00};
    localparam logic [9:0] A_ST = {`PCC_IDX_STATUS, 2'b00};
    logic clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, xtal = 0;
    logic pllS = 0, clear = 0, oe, out, pd, ack, pin;
    logic [9:0] adr = 0;
    logic [3:0] sel = 0, tmr = 0;
    logic [31:0] dat = 0, q, rdat;
    logic [4:0] mult;
    int failures = 0, numChecks = 0, rise, c;
    pcc_clock_control uut (.clk(clk), .reset_n(reset_n), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(rdat), .ack_o(ack), .xtalLevel(xtal),
        .pllStageOneLevel(pllS), .timerZeroOverflow(tmr[0]),
        .timerOneOverflow(tmr[1]), .timerTwoOverflow(tmr[2]),
        .timerThreeOverflow(tmr[3]), .auxClockPinIn(pin),
        .auxClockPinOut(out), .auxClockPinOe(oe), .pllPowerDown(pd),
        .pllMultiplier(mult));
    pcc_pin_load load (.clk(clk), .clear(clear), .pinOut(out), .pinOe(oe),
        .pinLevel(pin), .riseCount(rise));
    always #25 clk = !clk;
    // Crystal rises every second cycle; first PLL stage too while pd is low
    always @(posedge clk) begin
        xtal <= !xtal;
        pllS <= !pd && !pllS;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e, input string m);
        numChecks++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: %s got %h", $time, m, g);
        end
    endtask
    task automatic near(input int g, e, input string m);
        numChecks++;
        if (g > e + 1 || g < e - 1) begin
            failures++;
            $display("mismatch at %0t: %s count %0d", $time, m, g);
        end
    endtask
    // One classic cycle; request held until ack is sampled
    task automatic bus(input logic w, input logic [9:0] a,
                       input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
        // Waits for the answer however long; the watchdog ends a hang
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        chk(n, 2, "ack latency");
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, a, 4'hF, {24'h000000, d});
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, 4'hF, 32'h0);
        chk(q, e, "read");
    endtask
    task automatic count(input int n);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        repeat (n) @(posedge clk);
        c = rise;
    endtask
    logic [7:0] ct[7] = '{8'h28, 8'h38, 8'h30, 8'h08, 8'hC8, 8'hF8, 8'h2C};
    logic [1:0] lv[7] = '{2'b10, 2'b11, 0, 0, 0, 0, 2'b10};
    logic [7:0] rt[5] = '{8, 16, 254, 7, 255};
    int rc[5] = '{64, 32, 2, 0, 0};
    logic [4:0] mf[4] = '{5'h17, 5'h1B, 5'h1C, 5'h17};
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        rd(A_CTL, 32'h0);
        rd(A_RAT, 32'h8);
        rd(10'h3FC, 32'h0);
        bus(1'b1, A_RAT, 4'hE, 32'h55);
        rd(A_RAT, 32'h8);
        for (int i = 0; i < 4; i++) begin
            wr(A_CTL, i[7:0]);
            @(posedge clk);
            chk(mult, mf[i], "multiplier");
        end
        for (int i = 0; i < 7; i++) begin
            wr(A_CTL, ct[i]);
            repeat (2) @(posedge clk);
            chk({pd, oe, out}, {ct[i][2], lv[i]}, "pin");
        end
        for (int k = 0; k < 4; k++) begin
            wr(A_CTL, {4'h4 + k[3:0], 4'h8});
            count(64);
            near(c, 32 >> k, "crystal division");
        end
        wr(A_CTL, 8'h18);
        for (int i = 0; i < 5; i++) begin
            wr(A_RAT, rt[i]);
            rd(A_RAT, rt[i]);
            count(1024);
            near(c, rc[i], "pll division");
        end
        wr(A_RAT, 8);
        wr(A_CTL, 8'h1C);
        count(256);
        chk(c, 0, "power down");
        rd(A_ST, 32'h00001704);
        for (int t = 0; t < 4; t++) begin
            wr(A_CTL, {4'h8 + t[3:0], 4'h8});
            count(3);
            for (int j = 0; j < 8; j++) begin
                tmr <= 4'h1 << (j % 4);
                @(posedge clk);
                tmr <= 4'h0;
                @(posedge clk);
            end
            repeat (3) @(posedge clk);
            chk(rise, 1, "timer toggle");
        end
        wr(A_CTL, 8'h38);
        rd(A_ST, 32'h00001707);
        wr(A_RAT, 8'hFF);
        wr(A_CTL, 8'hF9);
        rd(A_ST, 32'h00001B19);
        final_report;
    end
    initial begin
        #1000000;
        failures++;
        final_report;
    end
endmodule
